/* File: design/pin_mux_pkg.sv */
// Purpose: shared constants and types for the mode-dependent pin function block
// Assumes: one 125 MHz clock, Avalon-MM register slave with 32-bit data
// Notes: offsets are byte addresses, each register one aligned word
package pin_mux_pkg;

  // operating mode, one-hot; straps are {mode_select_b, mode_select_a}
  typedef enum logic [3:0]
  {
    MODE_BOOT = 4'b0001,
    MODE_TEST = 4'b0010,
    MODE_SINGLE = 4'b0100,
    MODE_EXPANDED = 4'b1000
  } op_mode_t;

  localparam logic [1:0] STRAP_BOOT = 2'h0;
  localparam logic [1:0] STRAP_TEST = 2'h1;
  localparam logic [1:0] STRAP_SINGLE = 2'h2;

  // register slave handshake state
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PORTA = 8'h04;
  localparam logic [7:0] OFF_PORTB = 8'h08;
  localparam logic [7:0] OFF_PORTC = 8'h0c;
  localparam logic [7:0] OFF_PORTC_DIR = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PINS = 8'h18;

  // control register fields
  localparam int CTRL_PA3_DIR = 0;
  localparam int CTRL_PA7_DIR = 1;
  localparam int CTRL_PA3_OC5 = 2;
  localparam int CTRL_IRV = 3;
  localparam int CTRL_OUTPUT_HANDSHAKE_STROBE_HIGH = 4;

  // status register fields
  localparam int STAT_INPUT_HANDSHAKE_STROBE_EVENT = 4;
  localparam int STAT_LATCH_LSB = 8;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;

  // system clocks per E-clock cycle
  localparam int E_DIV_DEFAULT = 4;

endpackage

/* File: design/e_cycle_gen.sv */
// Purpose: divides the system clock into E-clock cycles as enable pulses
// Assumes: DIV is even and at least 2
// Notes: E is low in the first half of a cycle and high in the second
`timescale 1ns/1ns
module e_cycle_gen
  import pin_mux_pkg::*;
#(
  parameter int DIV = E_DIV_DEFAULT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // E-clock timing
  output logic eClock,
  output logic cycleStart,
  output logic phaseEnd
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic eHigh;
    logic start;
    logic last;
  } gen_state_t;

  gen_state_t s_q;
  gen_state_t s_d;

  // free running divider; pulses are registered so they line up with eClock
  always_comb
  begin
    s_d = s_q;
    if (s_q.cnt == CW'(DIV - 1))
      s_d.cnt = '0;
    else
      s_d.cnt = s_q.cnt + CW'(1);
    s_d.start = (s_d.cnt == '0);
    s_d.eHigh = (s_d.cnt >= CW'(DIV / 2));
    s_d.last = (s_d.cnt == CW'(DIV - 1));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign eClock = s_q.eHigh;
  assign cycleStart = s_q.start;
  assign phaseEnd = s_q.last;

endmodule

/* File: design/mode_pin_mux.sv */
// Purpose: mode-dependent function of strobe pins, ports A, B and C
// Assumes: pins synchronous to sys_clk; cpu cycle info valid at cycleStart
// Notes: mode straps are caught while rst is high and frozen at release
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns

// Function
// - reset straps pick one of four modes
// - mode pin A becomes open-drain instruction start
// - instruction start low during opcode fetch cycle
// - single-chip: strobe A pin is input strobe
// - expanded: strobe A pin outputs address strobe
// - single-chip: strobe B is programmable output strobe
// - expanded: direction low on write, high read
// - direction stays low across back-to-back writes
// - read visibility drives internal reads on port C
// - ports A, D, E ignore mode
// - port B: outputs, or address high byte
// - port C: bidirectional, or address/data bus
// - port C: address low, then data in E-high
// - port B shows address 15..8 every cycle
// - port A: three captures, four compares, one selectable
// - unused port A pins act as general I/O
// - only port A bits 7,3 have programmable direction
// - port A bit 7 always feeds pulse accumulator
module mode_pin_mux
  import pin_mux_pkg::*;
#(
  parameter int E_DIV = E_DIV_DEFAULT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register slave, Avalon-MM
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // mode straps; pin A doubles as open-drain instruction start
  input wire logic modeSelectA,
  input wire logic modeSelectB,
  output logic instructionStartNOut,
  output logic instructionStartNOe,
  // cpu bus cycle, sampled at cycleStart
  output logic eClock,
  output logic cycleStart,
  input wire logic cpuOpFetch,
  input wire logic cpuExtValid,
  input wire logic cpuWrite,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0] cpuWdata,
  input wire logic cpuIntRead,
  input wire logic [7:0] cpuIntData,
  output logic [7:0] cpuRdata,
  output logic cpuRdataValid,
  // strobe A / address strobe pin
  input wire logic strobeAIn,
  output logic strobeAOut,
  output logic strobeAOe,
  // strobe B / read-write pin
  output logic strobeBOut,
  output logic strobeBOe,
  // port A and timer hookup
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  input wire logic [4:0] timerPinEn,
  input wire logic [4:0] timerPinLevel,
  output logic [3:0] timerCapture,
  output logic pulseAccumInput,
  // port B, output only
  output logic [7:0] portBOut,
  output logic [7:0] portBOe,
  // port C
  input wire logic [7:0] portCIn,
  output logic [7:0] portCOut,
  output logic [7:0] portCOe,
  // current mode
  output op_mode_t opMode
);

  typedef struct packed
  {
    bus_state_t bus;
    logic [31:0] rdata;
    op_mode_t mode;
    logic [7:0] ctrl;
    logic [7:0] portAData;
    logic [7:0] portBData;
    logic [7:0] portCData;
    logic [7:0] portCDir;
    logic [7:0] portCLatch;
    logic straPrev;
    logic straEvent;
    logic strbActive;
    logic instruction_start_n;
    logic extValid;
    logic extWrite;
    logic irvRead;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] idata;
    logic rwLevel;
    logic [7:0] rdOut;
    logic rdValid;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic phaseEnd;

  // expanded and test modes run the multiplexed bus
  function automatic logic isExpanded(input op_mode_t m);
    return (m == MODE_EXPANDED) || (m == MODE_TEST);
  endfunction

  function automatic op_mode_t strapToMode(input logic [1:0] strap);
    case (strap)
      STRAP_BOOT: return MODE_BOOT;
      STRAP_TEST: return MODE_TEST;
      STRAP_SINGLE: return MODE_SINGLE;
      default: return MODE_EXPANDED;
    endcase
  endfunction

  // register read mux; unmapped words read zero
  function automatic logic [31:0] regRead(input logic [ADDR_W-1:0] a, input state_t s,
                                          input logic [7:0] pa, input logic [7:0] pc);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      OFF_CTRL: v[7:0] = s.ctrl;
      OFF_PORTA: v[7:0] = s.portAData;
      OFF_PORTB: v[7:0] = s.portBData;
      OFF_PORTC: v[7:0] = s.portCData;
      OFF_PORTC_DIR: v[7:0] = s.portCDir;
      OFF_STATUS:
      begin
        v[3:0] = s.mode;
        v[STAT_INPUT_HANDSHAKE_STROBE_EVENT] = s.straEvent;
        v[STAT_LATCH_LSB +: 8] = s.portCLatch;
      end
      OFF_PINS: v[15:0] = {pc, pa};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  e_cycle_gen #(.DIV(E_DIV)) u_ecyc
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .eClock(eClock),
    .cycleStart(cycleStart),
    .phaseEnd(phaseEnd)
  );

  // next state: bus slave, register writes, bus cycle tracking, strobes
  always_comb
  begin
    logic wrHit;
    logic straRise;
    wrHit = 1'b0;
    straRise = 1'b0;
    s_d = s_q;

    // one wait cycle, then answer; writes land on the answer edge
    case (s_q.bus)
      BUS_IDLE:
      begin
        if (read || write)
        begin
          s_d.bus = BUS_ACK;
          s_d.rdata = regRead(address, s_q, portAIn, portCIn);
        end
      end
      BUS_ACK:
      begin
        s_d.bus = BUS_IDLE;
        wrHit = write && byteenable[0];
      end
      default: s_d.bus = BUS_IDLE;
    endcase

    if (wrHit)
    begin
      case (address)
        OFF_CTRL: s_d.ctrl = writedata[7:0];
        OFF_PORTA: s_d.portAData = writedata[7:0];
        OFF_PORTB: s_d.portBData = writedata[7:0];
        OFF_PORTC: s_d.portCData = writedata[7:0];
        OFF_PORTC_DIR: s_d.portCDir = writedata[7:0];
        OFF_STATUS:
        begin
          if (writedata[STAT_INPUT_HANDSHAKE_STROBE_EVENT])
            s_d.straEvent = 1'b0;
        end
        default: s_d.straEvent = s_q.straEvent;
      endcase
    end

    // single-chip input strobe latches port C; set beats a same-cycle clear
    s_d.straPrev = strobeAIn;
    straRise = strobeAIn && !s_q.straPrev && !isExpanded(s_q.mode);
    if (straRise)
    begin
      s_d.portCLatch = portCIn;
      s_d.straEvent = 1'b1;
    end

    // output strobe from each port B write until the end of that E cycle
    if (phaseEnd)
      s_d.strbActive = 1'b0;
    if (wrHit && address == OFF_PORTB && !isExpanded(s_q.mode))
      s_d.strbActive = 1'b1;

    // per-cycle capture of the cpu's bus intent
    if (cycleStart)
    begin
      s_d.instruction_start_n = cpuOpFetch;
      s_d.addr = cpuAddr;
      s_d.wdata = cpuWdata;
      s_d.idata = cpuIntData;
      s_d.extValid = cpuExtValid;
      s_d.extWrite = cpuExtValid && cpuWrite;
      s_d.irvRead = cpuIntRead && s_q.ctrl[CTRL_IRV];
      // only an external write drops the line, so writes in a row stay low
      s_d.rwLevel = !(cpuExtValid && cpuWrite);
    end

    // external read data is taken at the last clock of E high
    s_d.rdValid = 1'b0;
    if (phaseEnd && s_q.extValid && !s_q.extWrite && isExpanded(s_q.mode))
    begin
      s_d.rdOut = portCIn;
      s_d.rdValid = 1'b1;
    end
  end

  // straps are watched all through reset, so the value at release stays
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.bus <= BUS_IDLE;
      s_q.mode <= strapToMode({modeSelectB, modeSelectA});
      s_q.ctrl <= CTRL_RST;
      s_q.portAData <= PORT_RST;
      s_q.portBData <= PORT_RST;
      s_q.portCData <= PORT_RST;
      s_q.portCDir <= PORT_RST;
      s_q.rwLevel <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // bus answers
  assign waitrequest = (s_q.bus != BUS_ACK);
  assign readdata = s_q.rdata;
  assign cpuRdata = s_q.rdOut;
  assign cpuRdataValid = s_q.rdValid;
  assign opMode = s_q.mode;

  // open drain: pulls low only, never during reset since lir clears there
  assign instructionStartNOut = 1'b0;
  assign instructionStartNOe = s_q.instruction_start_n;

  // strobe pins change role with mode
  always_comb
  begin
    if (isExpanded(s_q.mode))
    begin
      strobeAOut = !eClock;
      strobeAOe = 1'b1;
      strobeBOut = s_q.rwLevel;
      // an internal read shown on port C releases the direction line during E high
      strobeBOe = !(s_q.irvRead && eClock);
    end
    else
    begin
      strobeAOut = 1'b0;
      strobeAOe = 1'b0;
      strobeBOut = s_q.strbActive ~^ s_q.ctrl[CTRL_OUTPUT_HANDSHAKE_STROBE_HIGH];
      strobeBOe = 1'b1;
    end
  end

  // ports B and C
  always_comb
  begin
    portBOe = 8'hff;
    if (isExpanded(s_q.mode))
    begin
      portBOut = s_q.addr[15:8];
      if (!eClock)
      begin
        portCOut = s_q.addr[7:0];
        portCOe = 8'hff;
      end
      else if (s_q.extWrite)
      begin
        portCOut = s_q.wdata;
        portCOe = 8'hff;
      end
      else if (s_q.irvRead)
      begin
        portCOut = s_q.idata;
        portCOe = 8'hff;
      end
      else
      begin
        portCOut = 8'h00;
        portCOe = 8'h00;
      end
    end
    else
    begin
      portBOut = s_q.portBData;
      portCOut = s_q.portCData;
      portCOe = s_q.portCDir;
    end
  end

  // port A: same in every mode; timer functions override general I/O
  always_comb
  begin
    portAOut = s_q.portAData;
    portAOe = 8'h00;
    // bits 2..0 are fixed inputs feeding the captures
    // bit 3: capture input, or fifth compare, else programmed direction
    if (s_q.ctrl[CTRL_PA3_OC5] && timerPinEn[0])
    begin
      portAOut[3] = timerPinLevel[0];
      portAOe[3] = 1'b1;
    end
    else if (s_q.ctrl[CTRL_PA3_OC5])
      portAOe[3] = s_q.ctrl[CTRL_PA3_DIR];
    // bits 6..4 are fixed outputs
    for (int i = 4; i < 7; i++)
    begin
      portAOe[i] = 1'b1;
      if (timerPinEn[i-3])
        portAOut[i] = timerPinLevel[i-3];
    end
    if (timerPinEn[4])
    begin
      portAOut[7] = timerPinLevel[4];
      portAOe[7] = 1'b1;
    end
    else
      portAOe[7] = s_q.ctrl[CTRL_PA7_DIR];
  end

  // captures 1..3 on bits 2..0, capture 4 on bit 3
  assign timerCapture = {portAIn[3], portAIn[0], portAIn[1], portAIn[2]};
  assign pulseAccumInput = portAIn[7];

endmodule

/* File: test/mode_pin_mux_asserts.sv */
// Purpose: port-level checks of the mode pin mux
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every mode_pin_mux instance
`timescale 1ns/1ns
module mode_pin_mux_asserts
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire logic instructionStartNOut,
  input wire logic instructionStartNOe,
  input wire logic eClock,
  input wire logic cycleStart,
  input wire logic cpuOpFetch,
  input wire logic cpuExtValid,
  input wire logic cpuWrite,
  input wire logic [15:0] cpuAddr,
  input wire logic strobeAOut,
  input wire logic strobeAOe,
  input wire logic strobeBOut,
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portAOe,
  input wire logic pulseAccumInput,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe,
  input wire logic [7:0] portCOut,
  input wire logic [7:0] portCOe,
  input wire op_mode_t opMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bus pins carry cpu cycles in expanded and test modes; checks cover expanded only
  logic ex;
  assign ex = (opMode == MODE_EXPANDED);

  // mode, instruction start and strobe pins
  a_mode_onehot: assert property ($onehot(opMode)) else $error("mode not one-hot");
  a_mode_frozen: assert property (!$past(rst) |-> $stable(opMode)) else $error("mode moved");
  a_lir_drain: assert property (instructionStartNOut == 1'b0) else $error("lir drives high");
  a_lir_fetch: assert property (cycleStart |=> instructionStartNOe == $past(cpuOpFetch))
    else $error("lir not on fetch");
  a_input_handshake_strobe_input: assert property (opMode == MODE_SINGLE |-> !strobeAOe)
    else $error("strobe A driven");
  a_as_strobe: assert property (ex |-> strobeAOe && strobeAOut == !eClock)
    else $error("bad address strobe");
  a_rw_level: assert property (
    ex && cycleStart && cpuExtValid |=> strobeBOut == !$past(cpuWrite))
    else $error("bad direction");
  a_rw_nogap: assert property (
    ex && cycleStart && cpuExtValid && cpuWrite && !strobeBOut |-> !strobeBOut ##1 !strobeBOut)
    else $error("direction glitch");
  // ports
  a_portb_drive: assert property (portBOe == 8'hff) else $error("port B released");
  a_addr_phase: assert property (
    ex && cycleStart && cpuExtValid
    |=> {portBOut, portCOut} == $past(cpuAddr) && portCOe == 8'hff)
    else $error("bad address phase");
  a_porta_fixed: assert property (portAOe[2:0] == 3'h0 && portAOe[6:4] == 3'h7)
    else $error("port A fixed dir");
  a_pai_follow: assert property (pulseAccumInput == portAIn[7]) else $error("pai lost");
endmodule

bind mode_pin_mux mode_pin_mux_asserts chk (.sys_clk, .rst, .instructionStartNOut,
  .instructionStartNOe, .eClock, .cycleStart, .cpuOpFetch, .cpuExtValid, .cpuWrite,
  .cpuAddr, .strobeAOut, .strobeAOe, .strobeBOut, .portAIn, .portAOe, .pulseAccumInput,
  .portBOut, .portBOe, .portCOut, .portCOe, .opMode);

/* File: test/ext_bus_model.sv */
// Purpose: external memory on the multiplexed expansion bus
// Assumes: read data = low address byte xor 5a
// Notes: port C input toggles except in E high with the direction line high and port C released
`timescale 1ns/1ns
module ext_bus_model
(
  // bus timing
  input wire logic sys_clk,
  input wire logic eClock,
  input wire logic addrStrobe,
  input wire logic rwLevel,
  input wire logic busOn,
  // multiplexed pins
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portCOut,
  input wire logic [7:0] portCOe,
  output logic [7:0] portCIn,
  // last write seen
  output logic [15:0] lastAddr,
  output logic [7:0] lastData
);
  logic [15:0] addrQ = 16'h0;
  logic [7:0] junkQ = 8'h3c;
  // released lines never hold a stale value, so a late sample shows up
  assign portCIn = (busOn && eClock && rwLevel && portCOe == 8'h00) ? addrQ[7:0] ^ 8'h5a : junkQ;
  // address latch and write capture
  always @(posedge sys_clk)
  begin
    junkQ <= ~junkQ;
    if (busOn && addrStrobe)
      addrQ <= {portBOut, portCOut};
    if (busOn && eClock && !rwLevel && portCOe == 8'hff)
    begin
      lastAddr <= addrQ;
      lastData <= portCOut;
    end
  end
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the mode pin mux
// Assumes: E_DIV of 4, byte lanes always enabled
// Notes: cpu inputs set after one cycle start are taken at the next
`timescale 1ns/1ns
module testbench
  import pin_mux_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, eClock, cycleStart, cpuRdataValid;
  logic [1:0] strap = 2'h3;
  logic cpuOpFetch = 1'b0;
  logic cpuExtValid = 1'b0;
  logic cpuWrite = 1'b0;
  logic [15:0] cpuAddr = 16'h0;
  logic [15:0] lastAddr;
  logic [7:0] cpuWdata = 8'h0;
  logic [7:0] portAIn = 8'h80;
  logic strobeAIn = 1'b0;
  logic strobeAOut, strobeBOut, strobeBOe;
  logic cpuIntRead = 1'b0;
  logic [7:0] cpuIntData = 8'h00;
  logic [4:0] timerPinEn = 5'h00;
  logic [4:0] timerPinLevel = 5'h00;
  logic [7:0] portAOut, portAOe;
  logic [3:0] timerCapture;
  logic [7:0] irvSeen = 8'h00;
  logic strbSeen = 1'b0;
  logic [7:0] cpuRdata, portBOut, portCIn, portCOut, portCOe, lastData;
  op_mode_t opMode;
  int fails = 0;
  int n_compared = 0;

  // device and far side
  mode_pin_mux #(.E_DIV(4)) uut (.sys_clk, .rst, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .modeSelectA(strap[0]),
    .modeSelectB(strap[1]), .instructionStartNOut(), .instructionStartNOe(), .eClock,
    .cycleStart, .cpuOpFetch, .cpuExtValid, .cpuWrite, .cpuAddr, .cpuWdata,
    .cpuIntRead, .cpuIntData, .cpuRdata, .cpuRdataValid, .strobeAIn,
    .strobeAOut, .strobeAOe(), .strobeBOut, .strobeBOe, .portAIn, .portAOut,
    .portAOe, .timerPinEn, .timerPinLevel, .timerCapture,
    .pulseAccumInput(), .portBOut, .portBOe(), .portCIn, .portCOut, .portCOe, .opMode);
  ext_bus_model mem (.sys_clk, .eClock, .addrStrobe(strobeAOut), .rwLevel(strobeBOut),
    .busOn(opMode === MODE_EXPANDED), .portBOut, .portCOut, .portCOe, .portCIn,
    .lastAddr, .lastData);

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  // watchers: strobe B pulse in single chip, port C while direction is released
  always @(posedge sys_clk)
  begin
    if (rst)
      strbSeen <= 1'b0;
    else if (opMode === MODE_SINGLE && strobeBOut === 1'b0)
      strbSeen <= 1'b1;
    if (strobeBOe === 1'b0)
      irvSeen <= portCOut;
  end

  task automatic test_done();
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // avalon access; the answer edge is the one where waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rst_dev(input logic [1:0] s);
    @(posedge sys_clk);
    rst <= 1'b1;
    strap <= s;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one cpu cycle request, taken at the following cycle start
  task automatic cpu(input logic f, input logic v, input logic w, input logic [15:0] a);
    do @(negedge sys_clk); while (cycleStart !== 1'b1);
    @(posedge sys_clk);
    cpuOpFetch <= f;
    cpuExtValid <= v;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuWdata <= a[7:0] ^ 8'hc3;
  endtask

  initial
  begin
    // every strap code, straps moved after release
    for (int i = 0; i < 4; i++)
    begin
      rst_dev(i[1:0]);
      strap <= ~strap;
      bus(1'b0, OFF_STATUS, 32'h0);
      cmp(q & 32'hf, 32'h1 << i);
    end
    // expanded: read visibility on, two writes back to back, a read, internal reads
    bus(1'b1, OFF_CTRL, 32'h08);
    cpu(1'b1, 1'b1, 1'b1, 16'h1234);
    cpu(1'b0, 1'b1, 1'b1, 16'h1235);
    cpu(1'b1, 1'b1, 1'b0, 16'h2342);
    cpu(1'b0, 1'b0, 1'b0, 16'h0000);
    cpuIntRead <= 1'b1;
    cpuIntData <= 8'h96;
    portAIn <= 8'h00;
    for (int n = 0; n < 20 && cpuRdataValid !== 1'b1; n++)
      @(negedge sys_clk);
    cmp(cpuRdata, 8'h42 ^ 8'h5a);
    cmp({lastAddr, lastData}, {16'h1235, 8'h35 ^ 8'hc3});
    repeat (8) @(posedge sys_clk);
    cmp(irvSeen, 8'h96);
    // single chip: port B and C as plain ports, strobe A as input
    rst_dev(2'h2);
    bus(1'b1, OFF_PORTB, 32'h3c);
    cmp(portBOut, 8'h3c);
    bus(1'b1, OFF_PORTC_DIR, 32'hff);
    bus(1'b1, OFF_PORTC, 32'h81);
    cmp({portCOe, portCOut}, 16'hff81);
    cmp({strbSeen, strobeBOut}, 2'h3);
    bus(1'b0, 8'h1c, 32'h0);
    cmp(q, 32'h0);
    strobeAIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    cmp((q >> 4) & 32'h1, 32'h1);
    // port A: compare drive overrides data, fifth compare on 3, direction bit on 7
    bus(1'b1, OFF_PORTA, 32'ha0);
    timerPinEn <= 5'h02;
    timerPinLevel <= 5'h02;
    portAIn <= 8'h0c;
    @(posedge sys_clk);
    cmp({portAOe, portAOut}, 16'h70b0);
    cmp(timerCapture, 4'h9);
    bus(1'b1, OFF_CTRL, 32'h06);
    timerPinEn <= 5'h01;
    timerPinLevel <= 5'h01;
    @(posedge sys_clk);
    cmp({portAOe, portAOut}, 16'hf8a8);
    test_done();
  end

  // watchdog at 10000 cycles, far beyond the couple of hundred cycles the tests need
  initial
  begin
    #80000;
    fails++;
    test_done();
  end
endmodule
